// >>> rtl/msir_irq_router.v
// Interrupt enable and pin routing logic of the accelerometer
`timescale 1ns/1ps
`default_nettype none
`include "msir_defines.vh"
module msir_irq_router (
   input wire clk,
   input wire resetn,
   input wire regWrite,
   input wire [7:0] regAddr,
   input wire [7:0] regWriteData,
   output reg [7:0] regReadData,
   input wire [7:0] eventFlags,
   input wire irqPolaritySelect,
   input wire irqDriveTypeSelect,
   output wire firstIrqPinOut,
   output wire firstIrqPinOutEnableN,
   output wire secondIrqPinOut,
   output wire secondIrqPinOutEnableN,
   output reg [7:0] sourceStatus
);
   // ==========================================================
   // Registers
   reg [7:0] interruptEnableMap;
   reg [7:0] interruptPinRouting;
   reg firstActive;
   reg secondActive;
   wire [7:0] gatedFlags;
   wire [7:0] firstSet;
   wire [7:0] secondSet;
   wire firstLevel;
   wire secondLevel;
   // Per-source event names, bit 1 has no source behind it
   wire sleepWakeEvent;
   wire fifoEvent;
   wire transientEvent;
   wire orientationEvent;
   wire pulseEvent;
   wire fallMotionEvent;
   wire sampleReadyEvent;
   // Per-source enable bits
   wire sleepWakeIrqEnable;
   wire fifoIrqEnable;
   wire transientIrqEnable;
   wire orientationIrqEnable;
   wire pulseIrqEnable;
   wire fallMotionIrqEnable;
   wire sampleReadyIrqEnable;
   // Per-source routing bits
   wire sleepWakeIrqRoute;
   wire fifoIrqRoute;
   wire transientIrqRoute;
   wire orientationIrqRoute;
   wire pulseIrqRoute;
   wire fallMotionIrqRoute;
   wire sampleReadyIrqRoute;
   // Lanes rebuilt from the named bits
   wire [7:0] laneEvent;
   wire [7:0] laneEnable;
   wire [7:0] laneRoute;
   wire enableWriteHit;
   wire routingWriteHit;

   // ==========================================================
   // Write decode
   assign enableWriteHit = regWrite &
      (regAddr == `MSIR_ENABLE_MAP_ADDR);
   assign routingWriteHit = regWrite &
      (regAddr == `MSIR_PIN_ROUTING_ADDR);

   // ==========================================================
   // Event names
   // Detectors own their flags; this block only gates and steers
   assign sleepWakeEvent = eventFlags[`MSIR_SLEEP_WAKE_BIT];
   assign fifoEvent = eventFlags[`MSIR_FIFO_BIT];
   assign transientEvent = eventFlags[`MSIR_TRANSIENT_BIT];
   assign orientationEvent = eventFlags[`MSIR_ORIENTATION_BIT];
   assign pulseEvent = eventFlags[`MSIR_PULSE_BIT];
   assign fallMotionEvent = eventFlags[`MSIR_FALL_MOTION_BIT];
   assign sampleReadyEvent = eventFlags[`MSIR_SAMPLE_READY_BIT];

   // ==========================================================
   // Enable bits
   assign sleepWakeIrqEnable =
      interruptEnableMap[`MSIR_SLEEP_WAKE_BIT];
   assign fifoIrqEnable =
      interruptEnableMap[`MSIR_FIFO_BIT];
   assign transientIrqEnable =
      interruptEnableMap[`MSIR_TRANSIENT_BIT];
   assign orientationIrqEnable =
      interruptEnableMap[`MSIR_ORIENTATION_BIT];
   assign pulseIrqEnable =
      interruptEnableMap[`MSIR_PULSE_BIT];
   assign fallMotionIrqEnable =
      interruptEnableMap[`MSIR_FALL_MOTION_BIT];
   assign sampleReadyIrqEnable =
      interruptEnableMap[`MSIR_SAMPLE_READY_BIT];

   // ==========================================================
   // Routing bits, same positions as the enables
   assign sleepWakeIrqRoute =
      interruptPinRouting[`MSIR_SLEEP_WAKE_BIT];
   assign fifoIrqRoute =
      interruptPinRouting[`MSIR_FIFO_BIT];
   assign transientIrqRoute =
      interruptPinRouting[`MSIR_TRANSIENT_BIT];
   assign orientationIrqRoute =
      interruptPinRouting[`MSIR_ORIENTATION_BIT];
   assign pulseIrqRoute =
      interruptPinRouting[`MSIR_PULSE_BIT];
   assign fallMotionIrqRoute =
      interruptPinRouting[`MSIR_FALL_MOTION_BIT];
   assign sampleReadyIrqRoute =
      interruptPinRouting[`MSIR_SAMPLE_READY_BIT];

   // ==========================================================
   // Lane vectors
   // Bit 1 is tied to zero so nothing can ride the empty lane
   assign laneEvent = {
      sleepWakeEvent,
      fifoEvent,
      transientEvent,
      orientationEvent,
      pulseEvent,
      fallMotionEvent,
      1'b0,
      sampleReadyEvent
   };

   assign laneEnable = {
      sleepWakeIrqEnable,
      fifoIrqEnable,
      transientIrqEnable,
      orientationIrqEnable,
      pulseIrqEnable,
      fallMotionIrqEnable,
      1'b0,
      sampleReadyIrqEnable
   };

   assign laneRoute = {
      sleepWakeIrqRoute,
      fifoIrqRoute,
      transientIrqRoute,
      orientationIrqRoute,
      pulseIrqRoute,
      fallMotionIrqRoute,
      1'b0,
      sampleReadyIrqRoute
   };

   // Bit 1 is never stored, so it always reads back as zero
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         interruptEnableMap <= `MSIR_ENABLE_RESET;
         interruptPinRouting <= `MSIR_ROUTING_RESET;
      end else begin
         if (enableWriteHit) begin
            interruptEnableMap <=
               regWriteData & `MSIR_IMPLEMENTED_MASK;
         end
         if (routingWriteHit) begin
            interruptPinRouting <=
               regWriteData & `MSIR_IMPLEMENTED_MASK;
         end
      end
   end

   // ==========================================================
   // Gating and steering, one lane per source
   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1) begin : lane
         // Positions 7..0, lane 1 carries only zeros
         assign gatedFlags[i] =
            laneEvent[i] & laneEnable[i];
         assign firstSet[i] =
            gatedFlags[i] & laneRoute[i];
         assign secondSet[i] =
            gatedFlags[i] & ~laneRoute[i];
      end
   endgenerate

   // Level follows the flags; no latching here, detectors hold them
   assign firstLevel = |firstSet;
   assign secondLevel = |secondSet;

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         firstActive <= 1'b0;
         secondActive <= 1'b0;
         sourceStatus <= 8'h00;
      end else begin
         firstActive <= firstLevel;
         secondActive <= secondLevel;
         sourceStatus <= gatedFlags & `MSIR_IMPLEMENTED_MASK;
      end
   end

   // ==========================================================
   // Pad drive: open-drain only pulls toward the asserted level
   assign firstIrqPinOut = firstActive ~^ irqPolaritySelect;
   assign secondIrqPinOut = secondActive ~^ irqPolaritySelect;
   assign firstIrqPinOutEnableN =
      irqDriveTypeSelect & ~firstActive;
   assign secondIrqPinOutEnableN =
      irqDriveTypeSelect & ~secondActive;

   // ==========================================================
   // Register read, unmapped addresses read zero
   always @* begin
      case (regAddr)
         `MSIR_ENABLE_MAP_ADDR: regReadData = interruptEnableMap;
         `MSIR_PIN_ROUTING_ADDR: regReadData = interruptPinRouting;
         `MSIR_SOURCE_STATUS_ADDR: regReadData = sourceStatus;
         default: regReadData = 8'h00;
      endcase
   end
endmodule
`default_nettype wire

// >>> rtl/msir_defines.vh
// Constants for the motion sensor interrupt enable and routing block
// Contract
// - Enable bit 7 gates the auto-sleep/wake event.
// - Enable bit 6 gates the FIFO event.
// - Enable bit 5 gates the transient event.
// - Enable bit 4 gates the orientation event.
// - Enable bit 3 gates the pulse event.
// - Enable bit 2 gates the freefall/motion event.
// - Enable bit 0 gates the data-ready event.
// - All enable bits reset to zero.
// - An event flag passes on only while its enable bit is set.
// - Each enabled source goes to exactly one of two pins.
// - Route bit 0 selects second pin, 1 selects first pin.
// - Routing bits use the same positions as enable bits.
// - All routing bits reset to zero, so second pin by default.
// - A pin asserts when any enabled source routed to it is active.
// - Polarity bit at reset 0 makes an asserted pin drive low.
// - Pin is push-pull by default, open-drain selectable.
`ifndef MSIR_DEFINES_VH
`define MSIR_DEFINES_VH
// ==========================================================
// Register offsets
`define MSIR_ENABLE_MAP_ADDR 8'h2D
`define MSIR_PIN_ROUTING_ADDR 8'h2E
`define MSIR_SOURCE_STATUS_ADDR 8'h0C
// ==========================================================
// Fields and reset values
`define MSIR_SLEEP_WAKE_BIT 7
`define MSIR_FIFO_BIT 6
`define MSIR_TRANSIENT_BIT 5
`define MSIR_ORIENTATION_BIT 4
`define MSIR_PULSE_BIT 3
`define MSIR_FALL_MOTION_BIT 2
`define MSIR_SAMPLE_READY_BIT 0
`define MSIR_IMPLEMENTED_MASK 8'hFD
`define MSIR_ENABLE_RESET 8'h00
`define MSIR_ROUTING_RESET 8'h00
`endif

// >>> tb/msir_host.sv
// Host side interrupt inputs, each line pulled up while released
`timescale 1ns/1ps
`default_nettype none
module msir_host (input wire [1:0] pinOut, enN, output wire [1:0] line);
   assign line = pinOut | enN;
endmodule
`default_nettype wire

// >>> tb/msir_irq_router_properties.sv
// Port assertions for the interrupt router
`timescale 1ns/1ps
`default_nettype none
module msir_props (input wire clk, resetn, irqPolaritySelect,
   input wire irqDriveTypeSelect, firstIrqPinOut, secondIrqPinOut,
   input wire secondIrqPinOutEnableN, firstIrqPinOutEnableN,
   input wire [7:0] regAddr,
   input wire [7:0] regReadData, eventFlags, sourceStatus);
   // Asserted flags of both pins, first pin in bit 1
   wire [1:0] act = {firstIrqPinOut, secondIrqPinOut} ~^
      {irqPolaritySelect, irqPolaritySelect};
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   AST_B1: assert property (!regReadData[1] && !sourceStatus[1])
      else $error("bit one set");
   AST_RST: assert property (!$past(resetn) && regAddr == 8'h2D |->
      regReadData == 8'h00) else $error("enable map not cleared");
   AST_SRC: assert property (regAddr == 8'h0C |->
      regReadData == sourceStatus) else $error("source read");
   AST_GATE: assert property (!(sourceStatus & ~$past(eventFlags)))
      else $error("flag passed without event");
   AST_IDLE: assert property (!sourceStatus |-> !act)
      else $error("pin asserted with no source");
   AST_ANY: assert property (sourceStatus != 8'h00 |-> act != 2'h0)
      else $error("enabled source reached no pin");
   AST_PP: assert property (!irqDriveTypeSelect |->
      !secondIrqPinOutEnableN) else $error("push-pull not driving");
   AST_OD: assert property (irqDriveTypeSelect |->
      secondIrqPinOutEnableN == !act[0]) else $error("open drain enable");
   AST_OD_FIRST: assert property (irqDriveTypeSelect |->
      firstIrqPinOutEnableN == !act[1]) else $error("first open drain");
endmodule
bind msir_irq_router msir_props chk (.clk, .resetn, .irqPolaritySelect,
   .irqDriveTypeSelect, .firstIrqPinOut, .secondIrqPinOut, .regAddr,
   .secondIrqPinOutEnableN, .firstIrqPinOutEnableN, .regReadData,
   .eventFlags, .sourceStatus);
`default_nettype wire

// >>> tb/tb_msir_irq_router.sv
// Random register and event traffic against a queued scoreboard
`timescale 1ns/1ps
`default_nettype none
module tb_msir_irq_router;
   logic clk = 0, resetn = 0, regWrite = 0, pol = 0, od = 0;
   logic [7:0] regAddr = 8'h2D, regWriteData = 8'h00, eventFlags = 8'h00;
   logic [7:0] en = 8'h00, rt = 8'h00, s;
   logic [2:0] r;
   logic [1:0] a;
   logic [17:0] q[$];
   wire [7:0] regReadData, sourceStatus;
   wire [1:0] o, n, line;
   int err_total = 0, check_count = 0;
   msir_irq_router dut (.clk, .resetn, .regWrite, .regAddr, .regWriteData,
      .regReadData, .eventFlags, .irqPolaritySelect(pol), .sourceStatus,
      .irqDriveTypeSelect(od), .firstIrqPinOut(o[1]), .secondIrqPinOut(o[0]),
      .firstIrqPinOutEnableN(n[1]), .secondIrqPinOutEnableN(n[0]));
   msir_host host (.pinOut(o), .enN(n), .line);
   initial forever #5 clk = ~clk;
   task cmp(input logic [17:0] got, input logic [17:0] exp);
      check_count++;
      if (got !== exp) err_total++;
      if (got !== exp) $display("wrong value %0t %h %h", $time, got, exp);
   endtask
   always @(negedge clk) if (q.size() > 0)
      cmp({regReadData, line, sourceStatus}, q.pop_front());
   task finish_test;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      void'($urandom(32'h5CFC6F27));
      repeat (5) @(posedge clk);
      #1 resetn = 1;
      repeat (4000) begin
         @(posedge clk);
         #1 s = eventFlags & en;
         a = {|(s & rt), |(s & ~rt)};
         if (regWrite && regAddr == 8'h2D) en = regWriteData & 8'hFD;
         if (regWrite && regAddr == 8'h2E) rt = regWriteData & 8'hFD;
         {regWrite, regWriteData, eventFlags, pol, od, r} = 22'($urandom);
         od = od & ~pol; // Pull-up makes open drain usable active low only
         regAddr = r[2] ? {6'h0B, r[1:0]} : 8'h0C;
         q.push_back({regAddr == 8'h0C ? s : regAddr == 8'h2D ? en :
            regAddr == 8'h2E ? rt : 8'h00, a ~^ {pol, pol}, s});
      end
      $display("random traffic test done");
      @(posedge clk);
      finish_test;
   end
endmodule
`default_nettype wire
